// ===== core/ldf_core.sv
`timescale 1ns/10ps
// Overview of operation
// - burst dimming follows the dimming comparator output against its fixed level
// - integrator charge source on only while internal dimming signal is active
// - integrator discharge, proportional to sensed current, runs during brightness compensation
// - integrator held discharged while power-on reset is asserted
// - after soft start, LED current on only while integrator is above threshold
// - the two primary drives are complementary, half a period apart
// - resonant mode: full duty, frequency set by error amplifier level
// - PWM mode: fixed frequency, duty set by error amplifier level
// - sync mode: first drives N gate on positive, second P gate on negative
// - sync mode: leading-edge pulses ending at sync zero crossing
// - auxiliary drive leading-edge in resonant and sync, trailing-edge in PWM
// - after reset, integrator detached from dimming and charged by soft-start source
// - at threshold, soft start stops and comparator gates all three drives
// - sense below minimum at start-up count end declares failure, fault low
// - open-LED detection masked until start-up count expires
// - a present fault is counted; full count confirms it and drives fault low
// - fault counter ticks per drive period, cleared first and then periodically
// - sense above recovery level clears the fault counter unless over-current is present or still held
// - sense above over-current level is counted as a fault
// - sense above the short-circuit level is a short circuit
// - short circuit shuts the drives at once and raises fault without counting
// - mode chosen from the enable input voltage band
// - over-current held for a window; counter cleared if absent at its end
// - reset clears counters and fault latch and holds drives inactive
module ldf_core #(
    parameter int unsigned STARTUP_CNT = ldf_pkg::STARTUP_FULL,
    parameter int unsigned CLR_FIRST   = ldf_pkg::FAULT_CLR_FIRST,
    parameter int unsigned CLR_EVERY   = ldf_pkg::FAULT_CLR_EVERY
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_dim_above,
    input  wire logic       i_integ_above,
    input  wire logic       i_current_sense_input_above_min,
    input  wire logic       i_current_sense_input_above_rec,
    input  wire logic       i_current_sense_input_above_oc,
    input  wire logic       i_current_sense_input_above_sc,
    input  wire logic       i_sync_uv_low,
    input  wire logic       i_sync_positive,
    input  wire logic       i_en_above_l1,
    input  wire logic       i_en_above_l2,
    input  wire logic       i_en_above_l3,
    input  wire logic [7:0] i_comp_level,
    output logic            o_primary_drive_first,
    output logic            o_primary_drive_second,
    output logic            o_aux_drive,
    output logic            o_fault_n,
    output logic            o_integ_reset,
    output logic            o_softstart_en,
    output logic            o_integ_dim_connect,
    output logic            o_integ_charge_en,
    output logic            o_integ_discharge_en
);
    localparam int unsigned SU_W  = $clog2(STARTUP_CNT) + 1;
    localparam int unsigned SCH_W = $clog2(CLR_EVERY) + 1;

    // refuse counts the counters cannot hold
    if (STARTUP_CNT < 2 || CLR_FIRST < 2 || CLR_EVERY < 2 || CLR_FIRST > CLR_EVERY) begin : g_bad_param
        $error("ldf_core: counts must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset release and input synchronisers
    logic [1:0]                 rst_pipe_r;
    logic                       rst_n;
    logic [ldf_pkg::SYNC_W-1:0] sync1_r;
    logic [ldf_pkg::SYNC_W-1:0] sync2_r;

    // reset asserts at once but releases through two flops
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) rst_pipe_r <= 2'h0;
        else           rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
    assign rst_n = rst_pipe_r[1];

    // comparator outputs are asynchronous; comp level is slow so bitwise sync is tolerable
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= ldf_pkg::SYNC_RST;
            sync2_r <= ldf_pkg::SYNC_RST;
        end else begin
            sync1_r <= {i_comp_level, i_en_above_l3, i_en_above_l2, i_en_above_l1, i_sync_positive,
                        i_sync_uv_low, i_current_sense_input_above_sc, i_current_sense_input_above_oc, i_current_sense_input_above_rec,
                        i_current_sense_input_above_min, i_integ_above, i_dim_above};
            sync2_r <= sync1_r;
        end
    end

    logic       dim_s, integ_s, min_s, rec_s, oc_s, sc_s, uv_s, pos_s;
    logic [7:0] comp_s;
    assign dim_s  = sync2_r[ldf_pkg::IDX_DIM];
    assign integ_s = sync2_r[ldf_pkg::IDX_ITG];
    assign min_s  = sync2_r[ldf_pkg::IDX_MIN];
    assign rec_s  = sync2_r[ldf_pkg::IDX_REC];
    assign oc_s   = sync2_r[ldf_pkg::IDX_OC];
    assign sc_s   = sync2_r[ldf_pkg::IDX_SC];
    assign uv_s   = sync2_r[ldf_pkg::IDX_UV];
    assign pos_s  = sync2_r[ldf_pkg::IDX_POS];
    assign comp_s = sync2_r[ldf_pkg::IDX_COMP +: 8];

    ////////////////////////////////////////////////////////////////////////////
    // mode and start-up sequence
    ldf_pkg::ldf_mode_e mode_r;
    ldf_pkg::ldf_seq_e  seq_r;
    logic               fault_r;
    logic               leds_on;

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n)                              mode_r <= ldf_pkg::LDF_MODE_RES;
        else if (sync2_r[ldf_pkg::IDX_L43])      mode_r <= ldf_pkg::LDF_MODE_SYNC;
        else if (sync2_r[ldf_pkg::IDX_L32])      mode_r <= ldf_pkg::LDF_MODE_PWM;
        else if (sync2_r[ldf_pkg::IDX_L17])      mode_r <= ldf_pkg::LDF_MODE_RES;
    end

    // hand over once integrator reaches threshold
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n)                                   seq_r <= ldf_pkg::LDF_SEQ_SOFT;
        else if (seq_r == ldf_pkg::LDF_SEQ_SOFT && integ_s) seq_r <= ldf_pkg::LDF_SEQ_RUN;
    end

    // comparator gates the LEDs; fault or short kills them at once
    assign leds_on = (seq_r == ldf_pkg::LDF_SEQ_RUN) && integ_s && !fault_r && !sc_s;

    // integrator held at zero in reset, soft-start source, compensation
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_integ_reset        <= 1'b1;
            o_softstart_en       <= 1'b0;
            o_integ_dim_connect  <= 1'b0;
            o_integ_charge_en    <= 1'b0;
            o_integ_discharge_en <= 1'b0;
        end else begin
            o_integ_reset        <= 1'b0;
            o_softstart_en       <= (seq_r == ldf_pkg::LDF_SEQ_SOFT);
            o_integ_dim_connect  <= (seq_r == ldf_pkg::LDF_SEQ_RUN);
            o_integ_charge_en    <= (seq_r == ldf_pkg::LDF_SEQ_RUN) && dim_s;
            o_integ_discharge_en <= (seq_r == ldf_pkg::LDF_SEQ_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // oscillator and sync measurement
    logic [7:0] half_len, hcnt_r;
    logic       phase_r, half_end, per_tick, pos_d_r, sync_edge;
    logic [8:0] scnt_r, slen_r;

    // resonant mode shortens the half-period as the error amplifier rises
    assign half_len = (mode_r == ldf_pkg::LDF_MODE_RES) ? (ldf_pkg::HALF_MAX - {1'b0, comp_s[7:1]})
                                                         : ldf_pkg::HALF_MAX;
    assign half_end = (hcnt_r >= half_len);
    assign per_tick = half_end && phase_r;
    assign sync_edge = (pos_s != pos_d_r);

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hcnt_r  <= 8'h00;
            phase_r <= 1'b0;
        end else if (half_end) begin
            hcnt_r  <= 8'h00;
            phase_r <= ~phase_r;
        end else begin
            hcnt_r  <= hcnt_r + 8'h01;
        end
    end

    // half-cycle length of the sync signal, kept to place the pulse before the crossing
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_d_r <= 1'b0;
            scnt_r  <= 9'h000;
            slen_r  <= 9'h1FF;
        end else begin
            pos_d_r <= pos_s;
            if (sync_edge) begin
                scnt_r <= 9'h000;
                slen_r <= scnt_r;
            end else if (scnt_r != 9'h1FF) begin
                scnt_r <= scnt_r + 9'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // drive formation
    logic a_nxt, b_nxt, c_nxt, sync_win;
    // window opens comp counts before the expected crossing; pulse ends at the crossing
    assign sync_win = !sync_edge && (({1'b0, scnt_r} + {2'h0, comp_s}) >= {1'b0, slen_r});

    always_comb begin
        a_nxt = 1'b0;
        b_nxt = 1'b0;
        c_nxt = 1'b0;
        unique case (mode_r)
            ldf_pkg::LDF_MODE_RES: begin
                a_nxt = !phase_r;
                b_nxt = phase_r;
                // leading edge aux, comp clocks wide like the trailing one
                c_nxt = ({1'b0, hcnt_r} + {1'b0, comp_s}) > {1'b0, half_len};
            end
            ldf_pkg::LDF_MODE_PWM: begin
                // duty from comp at fixed period
                a_nxt = !phase_r && (hcnt_r < comp_s);
                b_nxt = phase_r && (hcnt_r < comp_s);
                c_nxt = (hcnt_r < comp_s);
            end
            ldf_pkg::LDF_MODE_SYNC: begin
                // N gate on positive half, P gate on negative half
                a_nxt = pos_s && sync_win;
                b_nxt = !pos_s && sync_win;
                c_nxt = ({1'b0, hcnt_r} + {1'b0, comp_s}) > {1'b0, half_len};
            end
            default: a_nxt = 1'b0;
        endcase
    end

    // all three drives gated; P gate idles high in sync mode
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_primary_drive_first  <= 1'b0;
            o_primary_drive_second <= 1'b0;
            o_aux_drive            <= 1'b0;
        end else begin
            o_primary_drive_first  <= leds_on && a_nxt;
            o_primary_drive_second <= (mode_r == ldf_pkg::LDF_MODE_SYNC) ? !(leds_on && b_nxt)
                                                                          : (leds_on && b_nxt);
            o_aux_drive            <= leds_on && c_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // start-up timer, over-current hold, fault counter
    logic [SU_W-1:0]               su_r;
    logic [SCH_W-1:0]              sch_r;
    logic                          first_done_r, su_done, su_fail, clr_sched, oc_act, oc_expire;
    logic [ldf_pkg::OC_HOLD_W-1:0] oc_r;
    logic [8:0]                    fcnt_r;
    logic                          fault_cond, fcnt_clr, fault_nxt;

    assign su_done   = (su_r == SU_W'(STARTUP_CNT));
    // failure judged on the tick that completes the count
    assign su_fail   = per_tick && (su_r == SU_W'(STARTUP_CNT - 1)) && !min_s;
    assign clr_sched = per_tick && (first_done_r ? (sch_r == SCH_W'(CLR_EVERY - 1))
                                                 : (sch_r == SCH_W'(CLR_FIRST - 1)));
    assign oc_act    = oc_s || (oc_r != '0);
    assign oc_expire = (oc_r == ldf_pkg::OC_HOLD_W'(1)) && !oc_s;
    // open LED masked until start-up expiry, over-current counted
    assign fault_cond = (su_done && leds_on && !min_s) || oc_act || uv_s;
    // recovery level or an ended hold clears counting
    assign fcnt_clr  = clr_sched || (rec_s && !oc_act) || oc_expire;
    // fault set only, never cleared before reset
    assign fault_nxt = fault_r || sc_s || su_fail || (fcnt_r == 9'(ldf_pkg::FAULT_FULL));

    // start-up timer counts drive periods then stops
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n)                   su_r <= '0;
        else if (per_tick && !su_done) su_r <= su_r + SU_W'(1);
    end

    // first clear after the short interval, then at the long interval
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sch_r        <= '0;
            first_done_r <= 1'b0;
        end else if (clr_sched) begin
            sch_r        <= '0;
            first_done_r <= 1'b1;
        end else if (per_tick) begin
            sch_r        <= sch_r + SCH_W'(1);
        end
    end

    // retriggered hold of the over-current status, reloaded each cycle it is present
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n)          oc_r <= '0;
        else if (oc_s)       oc_r <= ldf_pkg::OC_HOLD_W'(ldf_pkg::OC_HOLD_CYC);
        else if (oc_r != '0) oc_r <= oc_r - ldf_pkg::OC_HOLD_W'(1);
    end

    // count per drive period while a fault is present
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n)                          fcnt_r <= 9'h000;
        else if (fcnt_r == 9'(ldf_pkg::FAULT_FULL)) fcnt_r <= fcnt_r;
        else if (fcnt_clr)                   fcnt_r <= 9'h000;
        else if (per_tick && fault_cond)     fcnt_r <= fcnt_r + 9'h001;
    end

    // fault latch, cleared only by reset
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_r   <= 1'b0;
            o_fault_n <= 1'b1;
        end else begin
            fault_r   <= fault_nxt;
            o_fault_n <= !fault_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_charge_dim: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (seq_r == ldf_pkg::LDF_SEQ_RUN && dim_s) |=> o_integ_charge_en)
        else $error("charge source not following dimming");
    a_discharge_run: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        $rose(seq_r == ldf_pkg::LDF_SEQ_RUN) |=> o_integ_discharge_en && !o_softstart_en)
        else $error("discharge not enabled at hand-over");
    a_hand_over: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (seq_r == ldf_pkg::LDF_SEQ_SOFT && integ_s) |=> ##1 (o_integ_dim_connect && !o_softstart_en))
        else $error("soft start did not hand over");
    a_gate_off: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        !leds_on |=> (!o_primary_drive_first && !o_aux_drive))
        else $error("drive active while gated off");
    a_no_overlap: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (mode_r != ldf_pkg::LDF_MODE_SYNC && $past(mode_r) != ldf_pkg::LDF_MODE_SYNC)
        |-> !(o_primary_drive_first && o_primary_drive_second))
        else $error("primary drives overlap");
    a_pwm_period: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (mode_r == ldf_pkg::LDF_MODE_PWM && $past(mode_r) == ldf_pkg::LDF_MODE_PWM && $fell(phase_r))
        |-> $past(hcnt_r) == ldf_pkg::HALF_MAX)
        else $error("pwm half-period not fixed");
    a_sc_fault: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        sc_s |=> (!o_fault_n && !o_primary_drive_first && !o_aux_drive))
        else $error("short circuit not acted on at once");
    a_fault_hold: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        !o_fault_n |=> !o_fault_n [*2])
        else $error("fault output released");
    a_count_full: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (fcnt_r == 9'(ldf_pkg::FAULT_FULL - 1) && per_tick && fault_cond && !fcnt_clr) |=> ##1 !o_fault_n)
        else $error("full count not confirmed");
endmodule

// ===== core/ldf_pkg.sv
package ldf_pkg;
    // system clock
    localparam int unsigned CLK_PERIOD_NS   = 40;
    // over-current hold window, least time rounds up
    localparam int unsigned OC_HOLD_NS      = 50000;
    localparam int unsigned OC_HOLD_CYC     = (OC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OC_HOLD_W       = 11;
    // counts in drive periods
    localparam int unsigned STARTUP_FULL    = 32768;
    localparam int unsigned FAULT_CLR_FIRST = 32768;
    localparam int unsigned FAULT_CLR_EVERY = 65536;
    localparam int unsigned FAULT_FULL      = 256;
    // last count of the oscillator half-period in PWM and sync modes; there a half-period lasts HALF_MAX + 1 system clocks
    localparam logic [7:0]  HALF_MAX        = 8'hFF;
    // positions in the synchronised input vector
    localparam int unsigned IDX_DIM  = 0;
    localparam int unsigned IDX_ITG  = 1;
    localparam int unsigned IDX_MIN  = 2;
    localparam int unsigned IDX_REC  = 3;
    localparam int unsigned IDX_OC   = 4;
    localparam int unsigned IDX_SC   = 5;
    localparam int unsigned IDX_UV   = 6;
    localparam int unsigned IDX_POS  = 7;
    localparam int unsigned IDX_L17  = 8;
    localparam int unsigned IDX_L32  = 9;
    localparam int unsigned IDX_L43  = 10;
    localparam int unsigned IDX_COMP = 11;
    localparam int unsigned SYNC_W   = 19;
    localparam logic [SYNC_W-1:0] SYNC_RST = 19'h00000;

    typedef enum logic [1:0] {LDF_MODE_RES, LDF_MODE_PWM, LDF_MODE_SYNC} ldf_mode_e;
    typedef enum logic {LDF_SEQ_SOFT, LDF_SEQ_RUN} ldf_seq_e;
endpackage

// ===== sim/ldf_stage_model.sv
`timescale 1ns/10ps
// behavioural power stage, led strings and integrator capacitor
module ldf_stage_model (
    input  wire logic i_clk,
    input  wire logic i_drive_first,
    input  wire logic i_drive_second,
    input  wire logic i_integ_reset,
    input  wire logic i_softstart_en,
    input  wire logic i_charge_en,
    input  wire logic i_discharge_en,
    input  wire logic i_open_led,
    input  wire logic i_over_cur,
    input  wire logic i_short_cir,
    output logic      o_integ_above,
    output logic      o_current_sense_input_min,
    output logic      o_current_sense_input_rec,
    output logic      o_current_sense_input_oc,
    output logic      o_current_sense_input_sc
);
    logic [6:0] lit_r   = 7'h00;
    logic [7:0] integ_r = 8'h00;
    logic       led_on;

    ////////////////////////////////////////////////////////////////////////
    // inductor current lingers for a while after the drives stop
    always_ff @(posedge i_clk) begin
        if (i_drive_first || i_drive_second) begin
            lit_r <= 7'h40;
        end else if (lit_r != 7'h00) begin
            lit_r <= lit_r - 7'h01;
        end
    end
    assign led_on = (lit_r != 7'h00) && !i_open_led;

    ////////////////////////////////////////////////////////////////////////
    // integrator: charge wins over discharge so a steady dim input keeps it up
    always_ff @(posedge i_clk) begin
        if (i_integ_reset) begin
            integ_r <= 8'h00;
        end else if ((i_softstart_en || i_charge_en) && integ_r < 8'h50) begin
            integ_r <= integ_r + 8'h01;
        end else if (!i_charge_en && i_discharge_en && led_on && integ_r != 8'h00) begin
            integ_r <= integ_r - 8'h01;
        end
    end
    assign o_integ_above = integ_r > 8'h40;

    ////////////////////////////////////////////////////////////////////////
    // clean comparator levels
    assign o_current_sense_input_min = led_on;
    assign o_current_sense_input_rec = led_on;
    assign o_current_sense_input_oc  = led_on && i_over_cur;
    assign o_current_sense_input_sc  = i_short_cir;
endmodule

// ===== sim/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic       i_sys_clk       = 1'b0;
    logic       i_arst_n        = 1'b0;
    logic       i_dim_above     = 1'b1;
    logic       i_en_above_l1   = 1'b1;
    logic       i_en_above_l2   = 1'b0;
    logic       i_en_above_l3   = 1'b0;
    logic       sync_pos        = 1'b0;
    int         sync_cnt        = 0;
    logic [7:0] i_comp_level    = 8'h80;
    logic       open_led        = 1'b0;
    logic       over_cur        = 1'b0;
    logic       short_cir       = 1'b0;
    logic       integ_above, current_sense_input_min, current_sense_input_rec, current_sense_input_oc, current_sense_input_sc;
    logic       drv_a, drv_b, drv_c, fault_n, integ_reset, ss_en, dim_conn, chg_en, dis_en;
    int         bad_count       = 0;
    int         n_checks        = 0;

    ////////////////////////////////////////////////////////////////////////
    // short start-up count keeps the failure case brief
    ldf_core #(.STARTUP_CNT(8)) dut (
        .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_dim_above(i_dim_above),
        .i_integ_above(integ_above), .i_current_sense_input_above_min(current_sense_input_min), .i_current_sense_input_above_rec(current_sense_input_rec),
        .i_current_sense_input_above_oc(current_sense_input_oc), .i_current_sense_input_above_sc(current_sense_input_sc), .i_sync_uv_low(1'b0),
        .i_sync_positive(sync_pos), .i_en_above_l1(i_en_above_l1), .i_en_above_l2(i_en_above_l2),
        .i_en_above_l3(i_en_above_l3), .i_comp_level(i_comp_level), .o_primary_drive_first(drv_a),
        .o_primary_drive_second(drv_b), .o_aux_drive(drv_c), .o_fault_n(fault_n),
        .o_integ_reset(integ_reset), .o_softstart_en(ss_en), .o_integ_dim_connect(dim_conn),
        .o_integ_charge_en(chg_en), .o_integ_discharge_en(dis_en));
    ldf_stage_model u_stage (
        .i_clk(i_sys_clk), .i_drive_first(drv_a), .i_drive_second(drv_b),
        .i_integ_reset(integ_reset), .i_softstart_en(ss_en), .i_charge_en(chg_en),
        .i_discharge_en(dis_en), .i_open_led(open_led), .i_over_cur(over_cur),
        .i_short_cir(short_cir), .o_integ_above(integ_above), .o_current_sense_input_min(current_sense_input_min),
        .o_current_sense_input_rec(current_sense_input_rec), .o_current_sense_input_oc(current_sense_input_oc), .o_current_sense_input_sc(current_sense_input_sc));

    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog, the run needs roughly 90k cycles
    initial begin
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    // sync source: 200 clocks per half cycle, free running
    always @(posedge i_sys_clk) begin
        sync_cnt <= (sync_cnt == 199) ? 0 : sync_cnt + 1;
        if (sync_cnt == 199) begin
            sync_pos <= ~sync_pos;
        end
    end
    initial begin
        #(150000 * 40);
        bad_count++;
        give_verdict();
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reset held 20 cycles, then soft start must begin
    task automatic do_reset();
        @(posedge i_sys_clk);
        i_arst_n  <= 1'b0;
        open_led  <= 1'b0;
        over_cur  <= 1'b0;
        short_cir <= 1'b0;
        cyc(20);
        @(negedge i_sys_clk);
        check("outputs in reset", {drv_a, drv_b, drv_c, fault_n}, 4'h1);
        check("integ in reset", {integ_reset, ss_en, dim_conn, chg_en, dis_en}, 5'h10);
        @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        cyc(4);
        @(negedge i_sys_clk);
        check("soft start on", {integ_reset, ss_en, dim_conn, chg_en, dis_en}, 5'h08);
    endtask
    task automatic start_run();
        int n;
        n = 0;
        while (dim_conn !== 1'b1 && n < 300) begin
            @(posedge i_sys_clk);
            n++;
        end
        @(negedge i_sys_clk);
        check("handover", {ss_en, dim_conn, chg_en, dis_en}, 4'h7);
    endtask
    task automatic t_dim_charge();
        @(posedge i_sys_clk);
        i_dim_above <= 1'b0;
        cyc(4);
        @(negedge i_sys_clk);
        check("charge off", chg_en, 1'b0);
        @(posedge i_sys_clk);
        i_dim_above <= 1'b1;
        cyc(4);
        @(negedge i_sys_clk);
        check("charge on", chg_en, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // one full period of the first drive: length and on-times
    task automatic t_drive(input logic l2, input logic [7:0] comp, input int exp_per, input int exp_hi);
        int   n, hi_a, hi_b, hi_c, both;
        logic prev;
        n = 0;
        hi_c = 0;
        hi_a = 0;
        hi_b = 0;
        both = 0;
        @(posedge i_sys_clk);
        i_en_above_l2 <= l2;
        i_comp_level  <= comp;
        cyc(1200);
        while (drv_a !== 1'b0 && n < 1000) begin @(negedge i_sys_clk); n++; end
        while (drv_a !== 1'b1 && n < 2000) begin @(negedge i_sys_clk); n++; end
        n = 0;
        prev = 1'b1;
        while (!(drv_a === 1'b1 && prev === 1'b0) && n < 2000) begin
            hi_a += (drv_a === 1'b1);
            hi_b += (drv_b === 1'b1);
            both += (drv_a === 1'b1 && drv_b === 1'b1);
            hi_c += (drv_c === 1'b1);
            prev = drv_a;
            @(negedge i_sys_clk);
            n++;
        end
        check("period", n, exp_per);
        check("first on-time", hi_a, exp_hi);
        check("second on-time", hi_b, exp_hi);
        check("overlap", both, 0);
        check("aux on-time", hi_c, 2 * comp);
    endtask
    // sync mode: each pulse is comp clocks wide and ends at the crossing; second is active low
    task automatic t_sync();
        int hi_a, lo_b;
        hi_a = 0;
        lo_b = 0;
        @(posedge i_sys_clk);
        i_en_above_l3 <= 1'b1;
        i_comp_level  <= 8'h40;
        cyc(1300);
        repeat (400) begin
            @(negedge i_sys_clk);
            hi_a += (drv_a === 1'b1);
            lo_b += (drv_b === 1'b0);
        end
        check("sync first on-time", hi_a, 64);
        check("sync second on-time", lo_b, 64);
        @(posedge i_sys_clk);
        i_en_above_l3 <= 1'b0;
        cyc(20);
    endtask
    task automatic t_gate();
        int n, on;
        n = 0;
        on = 0;
        @(posedge i_sys_clk);
        i_dim_above <= 1'b0;
        while (integ_above !== 1'b0 && n < 500) begin @(posedge i_sys_clk); n++; end
        cyc(5);
        repeat (600) begin
            @(negedge i_sys_clk);
            on += (drv_a === 1'b1 || drv_b === 1'b1 || drv_c === 1'b1);
        end
        check("gated drives", on, 0);
        @(posedge i_sys_clk);
        i_dim_above <= 1'b1;
        n = 0;
        while (drv_a !== 1'b1 && n < 2000) begin @(negedge i_sys_clk); n++; end
        check("drive resumes", drv_a, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // fault scenarios, each from a fresh reset
    task automatic t_startfail();
        int n;
        n = 0;
        do_reset();
        @(posedge i_sys_clk);
        open_led <= 1'b1;
        start_run();
        while (fault_n !== 1'b0 && n < 20000) begin @(posedge i_sys_clk); n++; end
        cyc(300);
        @(negedge i_sys_clk);
        check("start-up failure", {fault_n, drv_a, drv_b, drv_c}, 4'h0);
    endtask
    task automatic t_short();
        do_reset();
        start_run();
        cyc(200);
        short_cir <= 1'b1;
        cyc(4);
        @(negedge i_sys_clk);
        check("short trips", {fault_n, drv_a, drv_b, drv_c}, 4'h0);
        @(posedge i_sys_clk);
        short_cir <= 1'b0;
        cyc(300);
        @(negedge i_sys_clk);
        check("short latched", {fault_n, drv_a, drv_b, drv_c}, 4'h0);
    endtask
    task automatic t_overcur();
        int n;
        n = 0;
        @(posedge i_sys_clk);
        i_en_above_l2 <= 1'b0;
        i_comp_level  <= 8'hFF;
        do_reset();
        start_run();
        cyc(100);
        over_cur <= 1'b1;
        while (fault_n !== 1'b0 && n < 70000) begin @(posedge i_sys_clk); n++; end
        // resonant half period is 129 clocks, so 256 periods take about 66048
        check("fault count span", (n >= 65790) && (n <= 66100), 1'b1);
        check("over-current fault", fault_n, 1'b0);
    endtask

    initial begin
        do_reset();
        start_run();
        t_dim_charge();
        t_drive(1'b0, 8'h80, 384, 192);
        t_drive(1'b0, 8'h40, 448, 224);
        t_drive(1'b1, 8'h80, 512, 128);
        t_drive(1'b1, 8'h40, 512, 64);
        t_sync();
        t_gate();
        t_startfail();
        t_short();
        t_overcur();
        give_verdict();
    end
endmodule
